// ==== design/sdrmb_col_gen.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdrmb_col_gen #(
	parameter int COL_BITS = sdrmb_pkg::COLS
) (
	input wire logic [COL_BITS-1:0] start_i,
	input wire logic [COL_BITS-1:0] beat_i,
	input wire logic [1:0] len_log_i,
	input wire logic page_i,
	input wire logic intl_i,
	output logic [COL_BITS-1:0] col_o
);
	import sdrmb_pkg::*;

	logic [COL_BITS-1:0] mask;
	logic [COL_BITS-1:0] low;

	assign mask = ~({COL_BITS{1'h1}} << len_log_i);

	always_comb begin
		low = intl_i ? (start_i ^ beat_i) : (start_i + beat_i);
		if (page_i) begin
			col_o = start_i + beat_i;
		end else begin
			col_o = (start_i & ~mask) | (low & mask);
		end
	end
endmodule
`default_nettype wire

// ==== design/sdrmb_ctl.sv ====
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sdrmb_ctl (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic [sdrmb_pkg::ABW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	sdrmb_if.ctl bus
);
	import sdrmb_pkg::*;

	sdrmb_eng_t eng_q;
	sdrmb_op_t op_q;
	logic [1:0] ba_q;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] mode_q;
	logic [DW-1:0] wdata_q;
	logic [DW-1:0] rdata_q;
	logic err_q;
	logic loaded_q;
	logic [NBANK-1:0] open_q;
	logic [7:0] rcd_q [NBANK];
	logic [7:0] rc_q [NBANK];
	logic [7:0] rrd_q;
	logic [7:0] mrd_q;
	logic [2:0] cap_q;
	logic [2:0] left_q;
	logic page_wr_q;
	logic cmd_wr;
	logic accept;
	logic refuse;
	logic ready;
	logic issue;
	logic drop;
	logic [2:0] pins;
	logic [2:0] bl;
	logic [2:0] cl;
	logic [2:0] left_init;
	logic [31:0] status;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	assign cmd_wr = avs_write_i && avs_address_i == REG_CMD;
	assign accept = (avs_read_i || avs_write_i) && avs_waitrequest_o &&
		!(cmd_wr && eng_q != ENG_IDLE);
	assign status = {24'h0, open_q, 1'h0, loaded_q, err_q,
		eng_q != ENG_IDLE};

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			avs_waitrequest_o <= 1'h1;
			avs_readdata_o <= 32'h0;
			wdata_q <= '0;
		end else begin
			avs_waitrequest_o <= !accept;
			if (accept && avs_read_i) begin
				case (avs_address_i)
					REG_WDATA: avs_readdata_o <= 32'(wdata_q);
					REG_RDATA: avs_readdata_o <= 32'(rdata_q);
					REG_STATUS: avs_readdata_o <= status;
					REG_MODE: avs_readdata_o <= 32'(mode_q);
					default: avs_readdata_o <= 32'h0;
				endcase
			end
			if (accept && avs_write_i && avs_address_i == REG_WDATA) begin
				wdata_q <= avs_writedata_i[DW-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Command check and engine
	// ----------------------------------------------------------------
	assign bl = addr_q[BL_MSB:BL_LSB];
	assign cl = addr_q[CL_MSB:CL_LSB];

	always_comb begin
		refuse = 1'h0;
		ready = 1'h1;
		case (op_q)
			OP_LMR: begin
				refuse = (|open_q) ||
					!(bl <= BL_8 || (bl == BL_PAGE && !addr_q[BT_BIT])) ||
					!(cl == CL_2 || cl == CL_3) ||
					addr_q[OPM_MSB:OPM_LSB] != 2'h0;
			end
			OP_ACTIVE: begin
				refuse = !loaded_q || open_q[ba_q];
				ready = rc_q[ba_q] == 8'h0 && rrd_q == 8'h0;
			end
			OP_READ, OP_WRITE: begin
				refuse = !loaded_q || !open_q[ba_q];
				ready = rcd_q[ba_q] == 8'h0;
			end
			default: begin
				refuse = 1'h0;
			end
		endcase
	end

	assign issue = eng_q == ENG_PEND && !refuse && ready &&
		mrd_q == 8'h0;
	assign drop = eng_q == ENG_PEND && refuse;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			eng_q <= ENG_IDLE;
			op_q <= OP_NOP;
			ba_q <= 2'h0;
			addr_q <= '0;
		end else begin
			case (eng_q)
				ENG_IDLE: begin
					if (accept && cmd_wr) begin
						eng_q <= ENG_PEND;
						op_q <= sdrmb_op_t'(avs_writedata_i[CMD_OP_LSB+:3]);
						ba_q <= avs_writedata_i[CMD_BA_LSB+:2];
						addr_q <= avs_writedata_i[CMD_ADDR_LSB+:AW];
					end
				end
				ENG_PEND: begin
					if (issue || drop) begin
						eng_q <= ENG_IDLE;
					end
				end
				default: begin
					eng_q <= ENG_IDLE;
				end
			endcase
		end
	end

	// A refused command wins over a clear in the same cycle.
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			err_q <= 1'h0;
		end else if (drop) begin
			err_q <= 1'h1;
		end else if (accept && avs_write_i && avs_address_i == REG_STATUS &&
			avs_writedata_i[ST_ERR]) begin
			err_q <= 1'h0;
		end
	end

	// ----------------------------------------------------------------
	// Command pins
	// ----------------------------------------------------------------
	always_comb begin
		case (op_q)
			OP_ACTIVE: pins = PIN_ACTIVE;
			OP_READ: pins = PIN_READ;
			OP_WRITE: pins = PIN_WRITE;
			OP_PRE: pins = PIN_PRE;
			OP_REF: pins = PIN_REF;
			OP_LMR: pins = PIN_LMR;
			OP_STOP: pins = PIN_STOP;
			default: pins = PIN_NOP;
		endcase
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus.cs_n <= 1'h1;
			{bus.ras_n, bus.cas_n, bus.we_n} <= PIN_NOP;
			bus.ba <= 2'h0;
			bus.addr <= '0;
		end else if (issue) begin
			bus.cs_n <= 1'h0;
			{bus.ras_n, bus.cas_n, bus.we_n} <= pins;
			bus.ba <= (op_q == OP_LMR) ? 2'h0 : ba_q;
			bus.addr <= (op_q == OP_LMR) ?
				{2'h0, addr_q[MODE_KEEP-1:0]} : addr_q;
		end else begin
			bus.cs_n <= 1'h1;
			{bus.ras_n, bus.cas_n, bus.we_n} <= PIN_NOP;
		end
	end

	// ----------------------------------------------------------------
	// Bank tracking and timers
	// ----------------------------------------------------------------
	generate
		for (genvar b = 0; b < NBANK; b++) begin : g_bank
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					open_q[b] <= 1'h0;
					rcd_q[b] <= 8'h0;
					rc_q[b] <= 8'h0;
				end else if (issue && op_q == OP_ACTIVE && ba_q == 2'(b)) begin
					open_q[b] <= 1'h1;
					rcd_q[b] <= 8'(RCD_CYC - 1);
					rc_q[b] <= 8'(RC_CYC - 1);
				end else begin
					if (issue && op_q == OP_PRE &&
						(addr_q[AP_BIT] || ba_q == 2'(b))) begin
						open_q[b] <= 1'h0;
					end
					if (rcd_q[b] != 8'h0) begin
						rcd_q[b] <= rcd_q[b] - 8'h1;
					end
					if (rc_q[b] != 8'h0) begin
						rc_q[b] <= rc_q[b] - 8'h1;
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rrd_q <= 8'h0;
		end else if (issue && op_q == OP_ACTIVE) begin
			rrd_q <= 8'(RRD_CYC - 1);
		end else if (rrd_q != 8'h0) begin
			rrd_q <= rrd_q - 8'h1;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mrd_q <= 8'h0;
			loaded_q <= 1'h0;
			mode_q <= '0;
		end else if (issue && op_q == OP_LMR) begin
			mrd_q <= 8'(MRD_CYC - 1);
			loaded_q <= 1'h1;
			mode_q <= {2'h0, addr_q[MODE_KEEP-1:0]};
		end else if (mrd_q != 8'h0) begin
			mrd_q <= mrd_q - 8'h1;
		end
	end

	// ----------------------------------------------------------------
	// Read capture and write drive
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cap_q <= 3'h0;
			rdata_q <= '0;
		end else begin
			if (issue && op_q == OP_READ) begin
				cap_q <= (mode_q[CL_MSB:CL_LSB] == CL_3) ? 3'h4 : 3'h3;
			end else if (cap_q != 3'h0) begin
				cap_q <= cap_q - 3'h1;
			end
			if (cap_q == 3'h1) begin
				rdata_q <= bus.dq;
			end
		end
	end

	always_comb begin
		case (mode_q[BL_MSB:BL_LSB])
			BL_2: left_init = 3'h1;
			BL_4: left_init = 3'h3;
			BL_8: left_init = 3'h7;
			default: left_init = 3'h0;
		endcase
		if (mode_q[WB_BIT]) begin
			left_init = 3'h0;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bus.dq_ctl <= '0;
			bus.dq_ctl_oe <= 1'h0;
			left_q <= 3'h0;
			page_wr_q <= 1'h0;
		end else if (issue && op_q == OP_WRITE) begin
			bus.dq_ctl <= wdata_q;
			bus.dq_ctl_oe <= 1'h1;
			left_q <= left_init;
			page_wr_q <= mode_q[BL_MSB:BL_LSB] == BL_PAGE && !mode_q[WB_BIT];
		end else if (issue) begin
			bus.dq_ctl_oe <= 1'h0;
			left_q <= 3'h0;
			page_wr_q <= 1'h0;
		end else if (left_q != 3'h0) begin
			left_q <= left_q - 3'h1;
		end else if (!page_wr_q) begin
			bus.dq_ctl_oe <= 1'h0;
		end
	end
endmodule
`default_nettype wire

// ==== design/sdrmb_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sdrmb_if;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic [1:0] ba;
	logic [sdrmb_pkg::AW-1:0] addr;
	logic [sdrmb_pkg::DW-1:0] dq_ctl;
	logic dq_ctl_oe;
	logic [sdrmb_pkg::DW-1:0] dq_mem;
	logic dq_mem_oe;
	logic [sdrmb_pkg::DW-1:0] dq;

	// Resolved data wire; an undriven bus reads as zero.
	assign dq = dq_mem_oe ? dq_mem : (dq_ctl_oe ? dq_ctl : '0);

	modport ctl(
		output cs_n, ras_n, cas_n, we_n, ba, addr, dq_ctl, dq_ctl_oe,
		input dq
	);
	modport mem(
		input cs_n, ras_n, cas_n, we_n, ba, addr, dq,
		output dq_mem, dq_mem_oe
	);
endinterface
`default_nettype wire

// ==== design/sdrmb_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdrmb_mem #(
	parameter int COL_BITS = sdrmb_pkg::COLS
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	sdrmb_if.mem bus,
	output logic [sdrmb_pkg::AW-1:0] mode_word_o,
	output logic [sdrmb_pkg::NBANK-1:0] bank_open_o
);
	import sdrmb_pkg::*;

	localparam int MW = COL_BITS + 2;
	localparam logic [COL_BITS-1:0] BEAT_ONE = COL_BITS'(1);

	logic [2:0] cmd;
	logic [AW-1:0] a_flat;
	logic [COL_BITS-1:0] col_in;
	logic [COL_BITS-1:0] col_burst;
	logic [COL_BITS-1:0] len_mask;
	logic [1:0] len_log;
	logic page;
	logic cl3;
	logic wr_single;
	logic rd_go;
	logic wr_go;
	logic ends;
	logic last;
	logic fetch;
	logic wr_beat;
	logic [DW-1:0] rd_word;

	sdrmb_bst_t bst_q;
	logic [1:0] bank_q;
	logic [COL_BITS-1:0] start_q;
	logic [COL_BITS-1:0] beat_q;
	logic [1:0] len_log_q;
	logic page_q;
	logic intl_q;
	logic [DW-1:0] p1_q;
	logic p1v_q;
	logic [DW-1:0] mem_q [2**MW];

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	assign cmd = bus.cs_n ? PIN_NOP : {bus.ras_n, bus.cas_n, bus.we_n};

	// Column bits skip the auto-precharge address bit.
	assign a_flat = {1'h0, bus.addr[AW-1], bus.addr[AP_BIT-1:0]};
	assign col_in = a_flat[COL_BITS-1:0];

	assign rd_go = (cmd == PIN_READ) && bank_open_o[bus.ba];
	assign wr_go = (cmd == PIN_WRITE) && bank_open_o[bus.ba];
	assign ends = (cmd == PIN_READ) || (cmd == PIN_WRITE) ||
		(cmd == PIN_STOP) || (cmd == PIN_PRE) || (cmd == PIN_LMR);

	// ----------------------------------------------------------------
	// Mode word
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_word_o <= MODE_RESET;
		end else if (cmd == PIN_LMR) begin
			mode_word_o <= bus.addr;
		end
	end

	always_comb begin
		len_log = 2'h0;
		page = 1'h0;
		case (mode_word_o[BL_MSB:BL_LSB])
			BL_2: len_log = 2'h1;
			BL_4: len_log = 2'h2;
			BL_8: len_log = 2'h3;
			BL_PAGE: page = 1'h1;
			default: len_log = 2'h0;
		endcase
	end

	// Reserved latency codes fall back to two cycles.
	assign cl3 = mode_word_o[CL_MSB:CL_LSB] == CL_3;
	assign wr_single = mode_word_o[WB_BIT];

	// ----------------------------------------------------------------
	// Bank state
	// ----------------------------------------------------------------
	generate
		for (genvar b = 0; b < NBANK; b++) begin : g_bank
			always_ff @(posedge clk_i or negedge reset_n_i) begin
				if (!reset_n_i) begin
					bank_open_o[b] <= 1'h0;
				end else if (cmd == PIN_ACTIVE && bus.ba == 2'(b)) begin
					bank_open_o[b] <= 1'h1;
				end else if (cmd == PIN_PRE &&
					(bus.addr[AP_BIT] || bus.ba == 2'(b))) begin
					bank_open_o[b] <= 1'h0;
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Burst sequencing
	// ----------------------------------------------------------------
	assign len_mask = ~({COL_BITS{1'h1}} << len_log_q);
	assign last = !page_q && (beat_q == len_mask);

	sdrmb_col_gen #(
		.COL_BITS(COL_BITS)
	) u_col (
		.start_i(start_q),
		.beat_i(beat_q),
		.len_log_i(len_log_q),
		.page_i(page_q),
		.intl_i(intl_q),
		.col_o(col_burst)
	);

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bst_q <= BST_IDLE;
			bank_q <= 2'h0;
			start_q <= '0;
			beat_q <= '0;
			len_log_q <= 2'h0;
			page_q <= 1'h0;
			intl_q <= 1'h0;
		end else if (rd_go || wr_go) begin
			bank_q <= bus.ba;
			start_q <= col_in;
			len_log_q <= len_log;
			page_q <= page;
			intl_q <= mode_word_o[BT_BIT];
			if (rd_go) begin
				bst_q <= BST_READ;
				beat_q <= '0;
			end else if (wr_single || (!page && len_log == 2'h0)) begin
				bst_q <= BST_IDLE;
			end else begin
				bst_q <= BST_WRITE;
				beat_q <= BEAT_ONE;
			end
		end else if (ends) begin
			bst_q <= BST_IDLE;
		end else begin
			case (bst_q)
				BST_IDLE: begin
					bst_q <= BST_IDLE;
				end
				BST_READ, BST_WRITE: begin
					if (last) begin
						bst_q <= BST_IDLE;
					end else begin
						beat_q <= beat_q + BEAT_ONE;
					end
				end
				default: begin
					bst_q <= BST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	assign fetch = (bst_q == BST_READ) && (cmd != PIN_WRITE) &&
		(cmd != PIN_LMR);
	assign wr_beat = (bst_q == BST_WRITE) && !ends;
	assign rd_word = mem_q[{bank_q, col_burst}];

	// The first write word is taken with the command itself.
	always_ff @(posedge clk_i) begin
		if (wr_go) begin
			mem_q[{bus.ba, col_in}] <= bus.dq;
		end else if (wr_beat) begin
			mem_q[{bank_q, col_burst}] <= bus.dq;
		end
	end

	// ----------------------------------------------------------------
	// Read latency pipeline
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			p1_q <= '0;
			p1v_q <= 1'h0;
			bus.dq_mem <= '0;
			bus.dq_mem_oe <= 1'h0;
		end else if (cmd == PIN_LMR || cmd == PIN_WRITE) begin
			p1v_q <= 1'h0;
			bus.dq_mem_oe <= 1'h0;
		end else begin
			p1_q <= rd_word;
			p1v_q <= fetch;
			// Word fetched at n+1 drives at n+2 or n+3.
			bus.dq_mem <= cl3 ? p1_q : rd_word;
			bus.dq_mem_oe <= cl3 ? p1v_q : fetch;
		end
	end
endmodule
`default_nettype wire

// ==== design/sdrmb_pkg.sv ====
package sdrmb_pkg;

	// ----------------------------------------------------------------
	// Widths and clock
	// ----------------------------------------------------------------
	localparam int AW = 12;
	localparam int DW = 16;
	localparam int COLS = 9;
	localparam int NBANK = 4;
	localparam int CLK_MHZ = 20;

	// ----------------------------------------------------------------
	// Mode word fields and codes
	// ----------------------------------------------------------------
	localparam int BL_LSB = 0;
	localparam int BL_MSB = 2;
	localparam int BT_BIT = 3;
	localparam int CL_LSB = 4;
	localparam int CL_MSB = 6;
	localparam int OPM_LSB = 7;
	localparam int OPM_MSB = 8;
	localparam int WB_BIT = 9;
	localparam int AP_BIT = 10;
	localparam int MODE_KEEP = 10;
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_2 = 3'h2;
	localparam logic [2:0] CL_3 = 3'h3;
	localparam logic [AW-1:0] MODE_RESET = 12'h020;

	// ----------------------------------------------------------------
	// Pin command codes, {ras_n, cas_n, we_n}
	// ----------------------------------------------------------------
	localparam logic [2:0] PIN_LMR = 3'h0;
	localparam logic [2:0] PIN_REF = 3'h1;
	localparam logic [2:0] PIN_PRE = 3'h2;
	localparam logic [2:0] PIN_ACTIVE = 3'h3;
	localparam logic [2:0] PIN_WRITE = 3'h4;
	localparam logic [2:0] PIN_READ = 3'h5;
	localparam logic [2:0] PIN_STOP = 3'h6;
	localparam logic [2:0] PIN_NOP = 3'h7;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int T_RCD_NS = 20;
	localparam int T_RC_NS = 70;
	localparam int T_RRD_NS = 20;
	localparam int T_MRD_CLK = 2;

	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RCD_CYC = ns_to_cyc(T_RCD_NS);
	localparam int RC_CYC = ns_to_cyc(T_RC_NS);
	localparam int RRD_CYC = ns_to_cyc(T_RRD_NS);
	localparam int MRD_CYC = T_MRD_CLK;

	// ----------------------------------------------------------------
	// Controller register map
	// ----------------------------------------------------------------
	localparam int ABW = 5;
	localparam logic [ABW-1:0] REG_CMD = 5'h00;
	localparam logic [ABW-1:0] REG_WDATA = 5'h04;
	localparam logic [ABW-1:0] REG_RDATA = 5'h08;
	localparam logic [ABW-1:0] REG_STATUS = 5'h0C;
	localparam logic [ABW-1:0] REG_MODE = 5'h10;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_BA_LSB = 4;
	localparam int CMD_ADDR_LSB = 16;
	localparam int ST_BUSY = 0;
	localparam int ST_ERR = 1;
	localparam int ST_LOADED = 2;
	localparam int ST_OPEN_LSB = 4;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		OP_NOP = 3'b000,
		OP_ACTIVE = 3'b001,
		OP_READ = 3'b010,
		OP_WRITE = 3'b011,
		OP_PRE = 3'b100,
		OP_REF = 3'b101,
		OP_LMR = 3'b110,
		OP_STOP = 3'b111
	} sdrmb_op_t;

	typedef enum logic [1:0] {
		BST_IDLE = 2'b00,
		BST_READ = 2'b01,
		BST_WRITE = 2'b10
	} sdrmb_bst_t;

	typedef enum logic {
		ENG_IDLE = 1'b0,
		ENG_PEND = 1'b1
	} sdrmb_eng_t;

endpackage

// ==== dv/sdram_mode_burst_activate_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdram_mode_burst_activate_tb;
	import sdrmb_pkg::*;
	typedef struct packed {
		logic [11:0] mode;
		logic [8:0] col;
		logic [3:0] n;
		logic [31:0] ord;
	} sdrmb_row_t;
	sdrmb_row_t rows [9] = '{
		'{12'h021, 9'h1, 4'h2, 32'h10000000},
		'{12'h022, 9'h1, 4'h4, 32'h12300000},
		'{12'h02A, 9'h1, 4'h4, 32'h10320000},
		'{12'h023, 9'h5, 4'h8, 32'h56701234},
		'{12'h02B, 9'h6, 4'h8, 32'h67452301},
		'{12'h032, 9'h3, 4'h4, 32'h30120000},
		'{12'h028, 9'h5, 4'h1, 32'h50000000},
		'{12'h02A, 9'h3, 4'h4, 32'h32100000},
		'{12'h022, 9'hD, 4'h4, 32'hDEFC0000}
	};
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [ABW-1:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [AW-1:0] mode_word;
	logic [NBANK-1:0] bank_open;
	logic [15:0] beats [$];
	int cyc = 0;
	int t_rd = 0;
	int t_dq = 0;
	int failures = 0;
	int total_checks = 0;
	sdrmb_if bus_if();
	sdrmb_ctl sdrmb_ctl_inst (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.avs_address_i(avs_address),
		.avs_read_i(avs_read),
		.avs_write_i(avs_write),
		.avs_writedata_i(avs_writedata),
		.avs_readdata_o(avs_readdata),
		.avs_waitrequest_o(avs_waitrequest),
		.bus(bus_if)
	);
	sdrmb_mem sdrmb_mem_inst (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.bus(bus_if),
		.mode_word_o(mode_word),
		.bank_open_o(bank_open)
	);
	sdrmb_monitor sdrmb_monitor_inst (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.cs_n(bus_if.cs_n),
		.ras_n(bus_if.ras_n),
		.cas_n(bus_if.cas_n),
		.we_n(bus_if.we_n),
		.ba(bus_if.ba),
		.addr(bus_if.addr),
		.dq_ctl_oe(bus_if.dq_ctl_oe),
		.dq_mem_oe(bus_if.dq_mem_oe)
	);
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	// Records read issue edges and every beat the device drives.
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (bus_if.cs_n === 1'b0 && {bus_if.ras_n, bus_if.cas_n,
			bus_if.we_n} === PIN_READ) begin
			t_rd = cyc;
		end
		if (bus_if.dq_mem_oe === 1'b1) begin
			if (beats.size() == 0) begin
				t_dq = cyc;
			end
			beats.push_back(bus_if.dq);
		end
	end
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic av(input logic w, input logic [ABW-1:0] a,
		input logic [31:0] d, output logic [31:0] r);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~w;
		avs_write <= w;
		do begin
			@(posedge clk_i);
		end while (avs_waitrequest !== 1'b0);
		r = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic cmd(input sdrmb_op_t op, input logic [1:0] b,
		input logic [11:0] a);
		logic [31:0] r;
		av(1'b1, REG_CMD, {4'h0, a, 10'h0, b, 1'b0, op}, r);
		do begin
			av(1'b0, REG_STATUS, 32'h0, r);
		end while (r[ST_BUSY] !== 1'b0);
	endtask
	task automatic prep(input logic [11:0] m);
		cmd(OP_PRE, 2'h0, 12'h000);
		cmd(OP_LMR, 2'h0, m);
		cmd(OP_ACTIVE, 2'h0, 12'h000);
		beats.delete();
	endtask
	task automatic rd(input logic [8:0] c);
		cmd(OP_READ, 2'h0, {3'h0, c});
		repeat (12) @(posedge clk_i);
	endtask
	initial begin
		repeat (40000) @(posedge clk_i);
		failures++;
		tally_and_finish();
	end
	initial begin
		int i;
		int j;
		int n1;
		logic [8:0] c;
		logic [31:0] r;
		repeat (8) @(posedge clk_i);
		chk({20'h0, mode_word}, {20'h0, MODE_RESET});
		chk({28'h0, bank_open}, 32'h0);
		reset_n_i <= 1'b1;
		cmd(OP_LMR, 2'h0, 12'h020);
		cmd(OP_ACTIVE, 2'h0, 12'h000);
		for (i = 0; i < 17; i++) begin
			c = (i == 16) ? 9'h1FF : 9'(i);
			av(1'b1, REG_WDATA, {16'h0, 7'h50, c}, r);
			cmd(OP_WRITE, 2'h0, {3'h0, c});
		end
		for (i = 0; i < 9; i++) begin
			prep(rows[i].mode);
			rd(rows[i].col);
			chk(32'(beats.size()), {28'h0, rows[i].n});
			for (j = 0; j < rows[i].n; j++) begin
				chk({16'h0, beats[j]}, {28'hA00, rows[i].ord[31-4*j-:4]});
			end
			chk(32'(t_dq - t_rd), {29'h0, rows[i].mode[6:4]});
			av(1'b0, REG_RDATA, 32'h0, r);
			chk({16'h0, r[15:0]}, {28'hA00, rows[i].ord[31:28]});
			chk({20'h0, mode_word}, {20'h0, rows[i].mode});
		end
		cmd(OP_LMR, 2'h0, 12'h023);
		chk({20'h0, mode_word}, 32'h022);
		av(1'b0, REG_STATUS, 32'h0, r);
		chk({28'h0, r[7:4]}, 32'h1);
		chk({31'h0, r[ST_ERR]}, 32'h1);
		av(1'b1, REG_STATUS, 32'h2, r);
		av(1'b0, REG_STATUS, 32'h0, r);
		chk({31'h0, r[ST_ERR]}, 32'h0);
		av(1'b0, 5'h14, 32'h0, r);
		chk(r, 32'h0);
		cmd(OP_ACTIVE, 2'h2, 12'h000);
		chk({28'h0, bank_open}, 32'h5);
		cmd(OP_PRE, 2'h0, 12'h400);
		chk({28'h0, bank_open}, 32'h0);
		prep(12'h222);
		av(1'b1, REG_WDATA, 32'hB008, r);
		cmd(OP_WRITE, 2'h0, 12'h008);
		rd(9'h8);
		chk(32'(beats.size()), 32'h4);
		chk({16'h0, beats[0]}, 32'hB008);
		chk({16'h0, beats[1]}, 32'hA009);
		prep(12'h022);
		av(1'b1, REG_WDATA, 32'hC00C, r);
		cmd(OP_WRITE, 2'h0, 12'h00C);
		rd(9'hC);
		chk(32'(beats.size()), 32'h4);
		for (j = 0; j < 4; j++) begin
			chk({16'h0, beats[j]}, 32'hC00C);
		end
		prep(12'h027);
		cmd(OP_READ, 2'h0, 12'h1FF);
		cmd(OP_STOP, 2'h0, 12'h000);
		repeat (8) @(posedge clk_i);
		n1 = beats.size();
		repeat (8) @(posedge clk_i);
		chk(32'(beats.size()), 32'(n1));
		chk({16'h0, beats[0]}, 32'hA1FF);
		chk({16'h0, beats[1]}, 32'hA000);
		chk({16'h0, beats[2]}, 32'hA001);
		reset_n_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk({20'h0, mode_word}, {20'h0, MODE_RESET});
		chk({28'h0, bank_open}, 32'h0);
		chk({31'h0, avs_waitrequest}, 32'h1);
		reset_n_i <= 1'b1;
		cmd(OP_ACTIVE, 2'h1, 12'h000);
		av(1'b0, REG_STATUS, 32'h0, r);
		chk(r, 32'h2);
		chk({28'h0, bank_open}, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ==== dv/sdrmb_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module sdrmb_monitor (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] ba,
	input wire logic [sdrmb_pkg::AW-1:0] addr,
	input wire logic dq_ctl_oe,
	input wire logic dq_mem_oe
);
	import sdrmb_pkg::*;
	logic lmr, act, rd, wr, pre;
	logic [AW-1:0] mode_q;
	logic [NBANK-1:0] open_q;
	assign lmr = !cs_n && {ras_n, cas_n, we_n} == PIN_LMR;
	assign act = !cs_n && {ras_n, cas_n, we_n} == PIN_ACTIVE;
	assign rd = !cs_n && {ras_n, cas_n, we_n} == PIN_READ;
	assign wr = !cs_n && {ras_n, cas_n, we_n} == PIN_WRITE;
	assign pre = !cs_n && {ras_n, cas_n, we_n} == PIN_PRE;
	// ----------------------------------------------------------------
	// Shadow of the stored mode word and of the open banks.
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_q <= MODE_RESET;
		end else if (lmr) begin
			mode_q <= addr;
		end
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			open_q <= '0;
		end else if (act) begin
			open_q[ba] <= 1'b1;
		end else if (pre) begin
			open_q <= addr[AP_BIT] ? '0 : open_q & ~(4'h1 << ba);
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);
	property p_lmr_addr;
		lmr |-> ba == 2'h0 && addr[AW-1:MODE_KEEP] == 2'h0;
	endproperty
	a_lmr_addr: assert property (p_lmr_addr)
		else $error("mode load with bank or top bits set");
	property p_lmr_opm;
		lmr |-> addr[OPM_MSB:OPM_LSB] == 2'h0;
	endproperty
	a_lmr_opm: assert property (p_lmr_opm)
		else $error("mode load with reserved operating mode");
	property p_lmr_idle;
		lmr |-> open_q == '0;
	endproperty
	a_lmr_idle: assert property (p_lmr_idle)
		else $error("mode load with a bank open");
	property p_lmr_hiz;
		lmr |=> cs_n && !dq_mem_oe ##1 !dq_mem_oe;
	endproperty
	a_lmr_hiz: assert property (p_lmr_hiz)
		else $error("data driven or command too soon after mode load");
	property p_acc_open;
		rd || wr |-> open_q[ba];
	endproperty
	a_acc_open: assert property (p_acc_open)
		else $error("access to an idle bank");
	property p_act_idle;
		act |-> !open_q[ba] && $past(cs_n);
	endproperty
	a_act_idle: assert property (p_act_idle)
		else $error("activate to an open bank");
	property p_rd_cl2;
		rd && mode_q[CL_MSB:CL_LSB] != CL_3 |-> ##2 dq_mem_oe;
	endproperty
	a_rd_cl2: assert property (p_rd_cl2)
		else $error("read data late at latency two");
	property p_rd_cl3;
		rd && mode_q[CL_MSB:CL_LSB] == CL_3 |-> ##3 dq_mem_oe;
	endproperty
	a_rd_cl3: assert property (p_rd_cl3)
		else $error("read data late at latency three");
	property p_wr_one;
		wr && (mode_q[WB_BIT] || mode_q[BL_MSB:BL_LSB] == BL_1)
			|-> dq_ctl_oe ##1 !dq_ctl_oe;
	endproperty
	a_wr_one: assert property (p_wr_one)
		else $error("single write drove more than one beat");
endmodule
`default_nettype wire
